// file: rtl/aout_pkg.sv
// Constants, types and helpers shared by the analog output register bank
package aout_pkg;

  // Register spaces
  localparam logic [1:0]  SP_COIL        = 2'h0;
  localparam logic [1:0]  SP_DISC        = 2'h1;
  localparam logic [1:0]  SP_INPUT       = 2'h2;
  localparam logic [1:0]  SP_HOLD        = 2'h3;

  // Offsets within each space
  localparam logic [15:0] OFS_FACTORY    = 16'h00e2;
  localparam logic [15:0] OFS_REBOOT     = 16'h00e9;
  localparam logic [15:0] OFS_OVP_EN     = 16'h0154;
  localparam logic [15:0] OFS_OVP_ALARM  = 16'h0168;
  localparam logic [15:0] OFS_FORMAT     = 16'h0277;
  localparam logic [15:0] OFS_CAL        = 16'h0278;
  localparam logic [15:0] OFS_RETAIN_EN  = 16'h0301;
  localparam logic [15:0] OFS_WIRE_BREAK = 16'h0122;
  localparam logic [15:0] OFS_READBACK   = 16'h0000;
  localparam logic [15:0] OFS_LAST       = 16'h0010;
  localparam logic [15:0] OFS_RETAINED   = 16'h0040;
  localparam logic [15:0] OFS_CH_COUNT   = 16'h014a;
  localparam logic [15:0] OFS_FW_VER     = 16'h015f;
  localparam logic [15:0] OFS_PAIR       = 16'h0168;
  localparam logic [15:0] OFS_OUT        = 16'h0000;
  localparam logic [15:0] OFS_STATION    = 16'h010f;
  localparam logic [15:0] OFS_POWERON    = 16'h0168;
  localparam logic [15:0] OFS_SAFE       = 16'h0188;
  localparam logic [15:0] OFS_RANGE      = 16'h01cb;
  localparam logic [15:0] OFS_SLEW       = 16'h020b;

  // Field positions and reset values
  localparam int          COIL_BIT       = 0;
  localparam logic [15:0] RST_WORD       = 16'h0000;
  localparam logic [7:0]  RST_STATION    = 8'h01;
  localparam logic [15:0] STATION_MIN    = 16'h0001;
  localparam logic [15:0] STATION_MAX    = 16'h00f7;
  localparam logic [7:0]  RANGE_0_20MA   = 8'h30;
  localparam logic [7:0]  RANGE_4_20MA   = 8'h31;
  localparam logic [7:0]  RANGE_0_10V    = 8'h32;
  localparam logic [7:0]  RANGE_0_5V     = 8'h34;
  localparam logic [7:0]  RST_RANGE      = RANGE_0_10V;
  localparam logic [7:0]  RST_SLEW       = 8'h00;
  localparam logic [7:0]  SLEW_MAX       = 8'h0e;

  // Timing: one output count per step at slew code 1 (0.0625 V/s on 10 V span)
  localparam int          CLK_HZ         = 40000000;
  localparam int          RAMP_STEP_NS   = 2441406;
  localparam int          RAMP_STEP_CYC  = RAMP_STEP_NS / 1000 * (CLK_HZ / 1000000)
                                           + (RAMP_STEP_NS % 1000) * (CLK_HZ / 1000000) / 1000;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } boot_state_e;

  // True when a lies in the block of n words starting at base
  function automatic logic in_block(input logic [15:0] a, input logic [15:0] base,
                                    input int n);
    logic [16:0] lim;
    lim = {1'b0, base} + 17'(n);
    in_block = (a >= base) && ({1'b0, a} < lim);
  endfunction : in_block

  // Channel index within a per-channel block
  function automatic logic [2:0] chan_of(input logic [15:0] a, input logic [15:0] base);
    logic [15:0] d;
    d = a - base;
    chan_of = d[2:0];
  endfunction : chan_of

  // Only the four documented span codes are accepted
  function automatic logic range_ok(input logic [15:0] v);
    range_ok = (v == {8'h00, RANGE_0_20MA}) || (v == {8'h00, RANGE_4_20MA}) ||
               (v == {8'h00, RANGE_0_10V}) || (v == {8'h00, RANGE_0_5V});
  endfunction : range_ok

endpackage : aout_pkg

// file: rtl/analog_output_if.sv
// Channel targets, slew codes and ramped levels between bank and ramp
`timescale 1ns/10ps
`default_nettype none
interface analog_output_if #(parameter int NCH = 8);
  logic [15:0] target [NCH];
  logic [7:0]  code   [NCH];
  logic [15:0] level  [NCH];
  modport ctl  (output target, output code, input level);
  modport ramp (input target, input code, output level);
endinterface : analog_output_if
`default_nettype wire

// file: rtl/input_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Stage one feeds only stage two; q moves once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
    end
  end
endmodule : input_sync
`default_nettype wire

// file: rtl/slew_ramp.sv
// Slew-rate limited output ramp for all channels
`timescale 1ns/10ps
`default_nettype none
module slew_ramp import aout_pkg::*; #(
  parameter int NCH      = 8,
  parameter int STEP_CYC = RAMP_STEP_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  analog_output_if.ramp   ch
);
  logic [31:0] tick_cnt;
  logic [15:0] next_level [NCH];
  wire  logic  tick = (tick_cnt == 32'(STEP_CYC - 1));

  // Step size doubles with each code; codes past the top clamp to it
  function automatic logic [15:0] step_of(input logic [7:0] c);
    logic [7:0] k;
    k = (c > SLEW_MAX) ? SLEW_MAX : c;
    step_of = 16'h0001 << (k[3:0] - 4'h1);
  endfunction : step_of

  // Free-running step timer shared by every channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tick_cnt <= '0;
    else tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
  end

  // Code 0 jumps straight to target; other codes move one step per tick, never overshooting
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      next_level[i] = ch.level[i];
      if (ch.code[i] == RST_SLEW) begin
        next_level[i] = ch.target[i];
      end else if (tick && ch.target[i] > ch.level[i]) begin
        next_level[i] = (ch.target[i] - ch.level[i] > step_of(ch.code[i])) ?
                        ch.level[i] + step_of(ch.code[i]) : ch.target[i];
      end else if (tick && ch.target[i] < ch.level[i]) begin
        next_level[i] = (ch.level[i] - ch.target[i] > step_of(ch.code[i])) ?
                        ch.level[i] - step_of(ch.code[i]) : ch.target[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) ch.level[i] <= RST_WORD;
    end else begin
      for (int i = 0; i < NCH; i++) ch.level[i] <= next_level[i];
    end
  end
endmodule : slew_ramp
`default_nettype wire

// file: rtl/analog_output_regs.sv
// Register bank of the networked analog output module
`timescale 1ns/10ps
`default_nettype none
module analog_output_regs import aout_pkg::*; #(
  parameter int          NCH        = 8,
  parameter int          RAMP_CYC   = RAMP_STEP_CYC,
  parameter logic [15:0] FW_VERSION = 16'h0123
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic [1:0]        REG_SPACE,
  input  wire logic [15:0]       REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [15:0]       REG_WDATA,
  output var  logic [15:0]       REG_RDATA,
  output var  logic              REG_ACK,
  output var  logic              REG_ERR,
  input  wire logic              NV_LD,
  input  wire logic [1:0]        NV_LD_SPACE,
  input  wire logic [15:0]       NV_LD_ADDR,
  input  wire logic [15:0]       NV_LD_DATA,
  input  wire logic              NV_DONE,
  output var  logic              NV_WR,
  output var  logic [1:0]        NV_WR_SPACE,
  output var  logic [15:0]       NV_WR_ADDR,
  output var  logic [15:0]       NV_WR_DATA,
  output var  logic              NV_FACTORY,
  output var  logic              REBOOT_REQ,
  output var  logic              CAL_RESTORE,
  input  wire logic              HOST_LOST,
  input  wire logic [NCH-1:0]    OVER_VALUE_TRIP,
  input  wire logic [NCH*16-1:0] READBACK,
  input  wire logic [NCH-1:0]    WIRE_BREAK,
  input  wire logic              PAIR_LINK,
  output wire logic [NCH*16-1:0] ANALOG_OUTPUT_LEVEL,
  output wire logic [NCH*8-1:0]  ANALOG_OUTPUT_RANGE,
  output var  logic              FORMAT_ENG,
  output logic [7:0]             STATION_ID,
  output logic [NCH-1:0]         OVER_VALUE_ALARM,
  output logic                   RUNNING
);

  boot_state_e    state;
  logic [NCH-1:0] ovp_en;
  logic [NCH-1:0] alarm;
  logic [NCH-1:0] retain_en;
  logic [NCH-1:0] safe_mode;
  logic [NCH-1:0] wire_break_s;
  logic           pair_s;
  logic           lost_q;
  logic [7:0]     station;
  logic [15:0]    out_val  [NCH];
  logic [15:0]    pon_val  [NCH];
  logic [15:0]    safe_val [NCH];
  logic [15:0]    ret_val  [NCH];
  logic [15:0]    readback [NCH];
  logic [7:0]     rng_code [NCH];
  logic [7:0]     slew     [NCH];

  analog_output_if #(.NCH(NCH)) aout_bus ();

  // Pins from outside the clock domain
  input_sync #(.W(NCH + 1)) u_sync (
    .clk (CLK),
    .rst (SYS_RST),
    .d   ({PAIR_LINK, WIRE_BREAK}),
    .q   ({pair_s, wire_break_s})
  );

  slew_ramp #(.NCH(NCH), .STEP_CYC(RAMP_CYC)) u_ramp (
    .clk (CLK),
    .rst (SYS_RST),
    .ch  (aout_bus.ramp)
  );

  // Safe value replaces the host value while the channel is in safe mode
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign aout_bus.target[g]           = safe_mode[g] ? safe_val[g] : out_val[g];
    assign aout_bus.code[g]             = slew[g];
    assign readback[g]                  = READBACK[g*16 +: 16];
    assign ANALOG_OUTPUT_LEVEL[g*16 +: 16] = aout_bus.level[g];
    assign ANALOG_OUTPUT_RANGE[g*8 +: 8]   = rng_code[g];
  end

  assign STATION_ID       = station;
  assign OVER_VALUE_ALARM = alarm;
  assign RUNNING          = (state == ST_RUN);

  // Write source: host while running, stored records while loading
  wire logic        loading = (state == ST_LOAD);
  wire logic        host_wr = REG_WR & RUNNING;
  wire logic        load_wr = NV_LD & loading;
  wire logic [1:0]  w_sp    = host_wr ? REG_SPACE : NV_LD_SPACE;
  wire logic [15:0] w_a     = host_wr ? REG_ADDR : NV_LD_ADDR;
  wire logic [15:0] w_d     = host_wr ? REG_WDATA : NV_LD_DATA;
  wire logic        w_bit   = w_d[COIL_BIT];
  wire logic        coil_w  = (w_sp == SP_COIL);
  wire logic        hold_w  = (w_sp == SP_HOLD);

  // Write decode; volatile targets accept host writes only
  wire logic h_fact  = host_wr & coil_w & (w_a == OFS_FACTORY);
  wire logic h_boot  = host_wr & coil_w & (w_a == OFS_REBOOT);
  wire logic h_cal   = host_wr & coil_w & (w_a == OFS_CAL);
  wire logic h_alarm = host_wr & coil_w & in_block(w_a, OFS_OVP_ALARM, NCH);
  wire logic h_out   = host_wr & hold_w & in_block(w_a, OFS_OUT, NCH);
  wire logic p_ovp   = coil_w & in_block(w_a, OFS_OVP_EN, NCH);
  wire logic p_fmt   = coil_w & (w_a == OFS_FORMAT);
  wire logic p_ret   = coil_w & in_block(w_a, OFS_RETAIN_EN, NCH);
  wire logic p_stn   = hold_w & (w_a == OFS_STATION) &
                       (w_d >= STATION_MIN) & (w_d <= STATION_MAX);
  wire logic p_pon   = hold_w & in_block(w_a, OFS_POWERON, NCH);
  wire logic p_safe  = hold_w & in_block(w_a, OFS_SAFE, NCH);
  wire logic p_rng   = hold_w & in_block(w_a, OFS_RANGE, NCH) & range_ok(w_d);
  wire logic p_slew  = hold_w & in_block(w_a, OFS_SLEW, NCH);
  wire logic p_rtv   = load_wr & (w_sp == SP_INPUT) & in_block(w_a, OFS_RETAINED, NCH);
  wire logic p_any   = p_ovp | p_fmt | p_ret | p_stn | p_pon | p_safe | p_rng | p_slew;
  wire logic per_wr  = (host_wr | load_wr) & p_any;
  wire logic host_ok = h_fact | h_boot | h_cal | h_alarm | h_out | (host_wr & p_any);
  wire logic fact_go = h_fact & w_bit;
  wire logic boot_go = h_boot & w_bit;
  wire logic cal_go  = h_cal & w_bit;

  wire logic [2:0] wc_ovp   = chan_of(w_a, OFS_OVP_EN);
  wire logic [2:0] wc_alarm = chan_of(w_a, OFS_OVP_ALARM);
  wire logic [2:0] wc_ret   = chan_of(w_a, OFS_RETAIN_EN);
  wire logic [2:0] wc_out   = chan_of(w_a, OFS_OUT);
  wire logic [2:0] wc_pon   = chan_of(w_a, OFS_POWERON);
  wire logic [2:0] wc_safe  = chan_of(w_a, OFS_SAFE);
  wire logic [2:0] wc_rng   = chan_of(w_a, OFS_RANGE);
  wire logic [2:0] wc_slew  = chan_of(w_a, OFS_SLEW);
  wire logic [2:0] wc_rtv   = chan_of(w_a, OFS_RETAINED);

  // Start-up: wait for the stored image, then apply initial outputs
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ST_LOAD;
    end else begin
      case (state)
        ST_LOAD: if (NV_DONE) state <= ST_RUN;
        ST_RUN:  if (boot_go) state <= ST_LOAD;
        default: state <= ST_LOAD;
      endcase
    end
  end

  // Persistent settings; factory restore puts back every default
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ovp_en     <= '0;
      retain_en  <= '0;
      FORMAT_ENG <= 1'b0;
      station    <= RST_STATION;
      for (int i = 0; i < NCH; i++) begin
        pon_val[i]  <= RST_WORD;
        safe_val[i] <= RST_WORD;
        rng_code[i] <= RST_RANGE;
        slew[i]     <= RST_SLEW;
      end
    end else if (fact_go) begin
      ovp_en     <= '0;
      retain_en  <= '0;
      FORMAT_ENG <= 1'b0;
      station    <= RST_STATION;
      for (int i = 0; i < NCH; i++) begin
        pon_val[i]  <= RST_WORD;
        safe_val[i] <= RST_WORD;
        rng_code[i] <= RST_RANGE;
        slew[i]     <= RST_SLEW;
      end
    end else if (per_wr) begin
      if (p_ovp) ovp_en[wc_ovp] <= w_bit;
      if (p_fmt) FORMAT_ENG <= w_bit;
      if (p_ret) retain_en[wc_ret] <= w_bit;
      if (p_stn) station <= w_d[7:0];
      if (p_pon) pon_val[wc_pon] <= w_d;
      if (p_safe) safe_val[wc_safe] <= w_d;
      if (p_rng) rng_code[wc_rng] <= w_d[7:0];
      if (p_slew) slew[wc_slew] <= w_d[7:0];
    end
  end

  // Retained value follows host writes while retention is enabled
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < NCH; i++) ret_val[i] <= RST_WORD;
    end else if (fact_go) begin
      for (int i = 0; i < NCH; i++) ret_val[i] <= RST_WORD;
    end else if (p_rtv) begin
      ret_val[wc_rtv] <= w_d;
    end else if (h_out && retain_en[wc_out]) begin
      ret_val[wc_out] <= w_d;
    end
  end

  // Host output values; at start-up retained or power-on value is applied
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < NCH; i++) out_val[i] <= RST_WORD;
    end else if (loading && NV_DONE) begin
      for (int i = 0; i < NCH; i++)
        out_val[i] <= retain_en[i] ? ret_val[i] : pon_val[i];
    end else if (h_out) begin
      out_val[wc_out] <= w_d;
    end
  end

  // Link loss forces safe values; a fresh write releases that channel
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lost_q    <= 1'b0;
      safe_mode <= '0;
    end else begin
      lost_q <= HOST_LOST;
      for (int i = 0; i < NCH; i++) begin
        if (HOST_LOST && !lost_q) safe_mode[i] <= 1'b1;
        else if (loading || (h_out && wc_out == 3'(i))) safe_mode[i] <= 1'b0;
      end
    end
  end

  // Alarm latch: a trip in the clearing cycle still sets the flag
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      alarm <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (OVER_VALUE_TRIP[i] && ovp_en[i]) alarm[i] <= 1'b1;
        else if (loading || (h_alarm && w_bit && wc_alarm == 3'(i)))
          alarm[i] <= 1'b0;
      end
    end
  end

  // Read decode per space
  wire logic r_coil = (REG_SPACE == SP_COIL);
  wire logic r_disc = (REG_SPACE == SP_DISC);
  wire logic r_inp  = (REG_SPACE == SP_INPUT);
  wire logic r_hold = (REG_SPACE == SP_HOLD);
  wire logic rh_ovp  = r_coil & in_block(REG_ADDR, OFS_OVP_EN, NCH);
  wire logic rh_alm  = r_coil & in_block(REG_ADDR, OFS_OVP_ALARM, NCH);
  wire logic rh_fmt  = r_coil & (REG_ADDR == OFS_FORMAT);
  wire logic rh_ret  = r_coil & in_block(REG_ADDR, OFS_RETAIN_EN, NCH);
  wire logic rh_wb   = r_disc & in_block(REG_ADDR, OFS_WIRE_BREAK, NCH);
  wire logic rh_rb   = r_inp & in_block(REG_ADDR, OFS_READBACK, NCH);
  wire logic rh_last = r_inp & in_block(REG_ADDR, OFS_LAST, NCH);
  wire logic rh_rtv  = r_inp & in_block(REG_ADDR, OFS_RETAINED, NCH);
  wire logic rh_cnt  = r_inp & (REG_ADDR == OFS_CH_COUNT);
  wire logic rh_ver  = r_inp & (REG_ADDR == OFS_FW_VER);
  wire logic rh_pair = r_inp & (REG_ADDR == OFS_PAIR);
  wire logic rh_out  = r_hold & in_block(REG_ADDR, OFS_OUT, NCH);
  wire logic rh_stn  = r_hold & (REG_ADDR == OFS_STATION);
  wire logic rh_pon  = r_hold & in_block(REG_ADDR, OFS_POWERON, NCH);
  wire logic rh_safe = r_hold & in_block(REG_ADDR, OFS_SAFE, NCH);
  wire logic rh_rng  = r_hold & in_block(REG_ADDR, OFS_RANGE, NCH);
  wire logic rh_slew = r_hold & in_block(REG_ADDR, OFS_SLEW, NCH);
  wire logic rd_ok   = rh_ovp | rh_alm | rh_fmt | rh_ret | rh_wb | rh_rb | rh_last |
                       rh_rtv | rh_cnt | rh_ver | rh_pair | rh_out | rh_stn | rh_pon |
                       rh_safe | rh_rng | rh_slew;

  // Read selection; write-only coils are not readable
  wire logic [15:0] rd_word =
    rh_ovp  ? {15'h0000, ovp_en[chan_of(REG_ADDR, OFS_OVP_EN)]} :
    rh_alm  ? {15'h0000, alarm[chan_of(REG_ADDR, OFS_OVP_ALARM)]} :
    rh_fmt  ? {15'h0000, FORMAT_ENG} :
    rh_ret  ? {15'h0000, retain_en[chan_of(REG_ADDR, OFS_RETAIN_EN)]} :
    rh_wb   ? {15'h0000, wire_break_s[chan_of(REG_ADDR, OFS_WIRE_BREAK)]} :
    rh_rb   ? readback[chan_of(REG_ADDR, OFS_READBACK)] :
    rh_last ? aout_bus.level[chan_of(REG_ADDR, OFS_LAST)] :
    rh_rtv  ? ret_val[chan_of(REG_ADDR, OFS_RETAINED)] :
    rh_cnt  ? 16'(NCH) :
    rh_ver  ? FW_VERSION :
    rh_pair ? {15'h0000, pair_s} :
    rh_out  ? out_val[chan_of(REG_ADDR, OFS_OUT)] :
    rh_stn  ? {8'h00, station} :
    rh_pon  ? pon_val[chan_of(REG_ADDR, OFS_POWERON)] :
    rh_safe ? safe_val[chan_of(REG_ADDR, OFS_SAFE)] :
    rh_rng  ? {8'h00, rng_code[chan_of(REG_ADDR, OFS_RANGE)]} :
    rh_slew ? {8'h00, slew[chan_of(REG_ADDR, OFS_SLEW)]} : 16'h0000;

  // Host answer one cycle after the request
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_ACK   <= 1'b0;
      REG_ERR   <= 1'b0;
      REG_RDATA <= 16'h0000;
    end else begin
      REG_ACK   <= REG_WR | REG_RD;
      REG_ERR   <= REG_WR ? ~host_ok : (REG_RD & ~rd_ok);
      REG_RDATA <= (REG_RD && !REG_WR && rd_ok) ? rd_word : 16'h0000;
    end
  end

  // Storage record per persistent write, plus one-shot commands
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      NV_WR       <= 1'b0;
      NV_WR_SPACE <= SP_COIL;
      NV_WR_ADDR  <= 16'h0000;
      NV_WR_DATA  <= 16'h0000;
      NV_FACTORY  <= 1'b0;
      REBOOT_REQ  <= 1'b0;
      CAL_RESTORE <= 1'b0;
    end else begin
      NV_WR       <= (host_wr & p_any) | (h_out & retain_en[wc_out]);
      NV_WR_SPACE <= h_out ? SP_INPUT : w_sp;
      NV_WR_ADDR  <= h_out ? OFS_RETAINED + {13'h0000, wc_out} : w_a;
      NV_WR_DATA  <= w_d;
      NV_FACTORY  <= fact_go;
      REBOOT_REQ  <= boot_go;
      CAL_RESTORE <= cal_go;
    end
  end

endmodule : analog_output_regs
`default_nettype wire

// file: testbench/aout_regs_properties.sv
// Port checks of the analog output register bank
`timescale 1ns/10ps
`default_nettype none
module aout_regs_properties import aout_pkg::*; (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic [1:0]  REG_SPACE,
  input wire logic [15:0] REG_ADDR,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_ACK,
  input wire logic        REG_ERR,
  input wire logic        NV_WR,
  input wire logic [15:0] NV_WR_DATA,
  input wire logic        NV_FACTORY,
  input wire logic        REBOOT_REQ,
  input wire logic        CAL_RESTORE,
  input wire logic [7:0]  STATION_ID,
  input wire logic        RUNNING
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Accepted coil commands and station writes; a refused one must leave no trace
  wire cmd = REG_WR && RUNNING && REG_SPACE == SP_COIL && REG_WDATA[0];
  wire stw = REG_WR && RUNNING && REG_SPACE == SP_HOLD && REG_ADDR == OFS_STATION;
  wire sok = REG_WDATA >= STATION_MIN && REG_WDATA <= STATION_MAX;
  ack_timing_a: assert property ((REG_WR || REG_RD) |=> REG_ACK)
    else $error("no answer");
  err_with_ack_a: assert property (REG_ERR |-> REG_ACK)
    else $error("lone error");
  station_span_a: assert property (STATION_ID >= 8'h01 && STATION_ID <= 8'hf7)
    else $error("station out of span");
  bad_station_a: assert property (stw && !sok |=> REG_ERR && !NV_WR)
    else $error("bad station taken");
  id_store_a: assert property (stw && sok |=> NV_WR && NV_WR_DATA == $past(REG_WDATA))
    else $error("station not stored");
  wo_read_a: assert property (REG_RD && !REG_WR && REG_SPACE == SP_COIL &&
    REG_ADDR == OFS_FACTORY |=> REG_ERR)
    else $error("command coil read");
  factory_cmd_a: assert property (cmd && REG_ADDR == OFS_FACTORY |=> NV_FACTORY)
    else $error("no erase");
  reboot_cmd_a: assert property (cmd && REG_ADDR == OFS_REBOOT |=> REBOOT_REQ)
    else $error("no restart");
  cal_cmd_a: assert property (cmd && REG_ADDR == OFS_CAL |=> CAL_RESTORE)
    else $error("no calibration reload");
endmodule : aout_regs_properties
bind analog_output_regs aout_regs_properties u_aout_regs_properties (.*);
`default_nettype wire

// file: testbench/nv_store_model.sv
// Behavioural settings store facing the register bank
`timescale 1ns/10ps
`default_nettype none
module nv_store_model (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        NV_WR,
  input wire logic [1:0]  NV_WR_SPACE,
  input wire logic [15:0] NV_WR_ADDR,
  input wire logic [15:0] NV_WR_DATA,
  input wire logic        NV_FACTORY,
  input wire logic        REBOOT_REQ,
  output logic            NV_LD,
  output logic [1:0]      NV_LD_SPACE,
  output logic [15:0]     NV_LD_ADDR,
  output logic [15:0]     NV_LD_DATA,
  output logic            NV_DONE
);
  logic [15:0] mem [logic [17:0]];
  // Replay after every restart; idle data toggles so stale values never match
  initial begin
    {NV_LD, NV_DONE, NV_LD_SPACE, NV_LD_ADDR, NV_LD_DATA} = '0;
    forever begin
      @(negedge SYS_RST or posedge REBOOT_REQ);
      foreach (mem[k]) begin
        @(posedge CLK);
        {NV_LD, NV_LD_SPACE, NV_LD_ADDR, NV_LD_DATA} <= {1'b1, k, mem[k]};
      end
      @(posedge CLK);
      {NV_LD, NV_DONE, NV_LD_DATA} <= {2'b01, ~NV_LD_DATA};
      @(posedge CLK);
      NV_DONE <= 1'b0;
    end
  end
  // Records survive reset, unlike the bank itself
  always @(posedge CLK) begin
    if (NV_FACTORY) mem.delete();
    else if (NV_WR) mem[{NV_WR_SPACE, NV_WR_ADDR}] = NV_WR_DATA;
  end
endmodule : nv_store_model
`default_nettype wire

// file: testbench/analog_output_register_map_tb_top.sv
// Self-checking bench for the analog output register bank
`timescale 1ns/10ps
`default_nettype none
module analog_output_register_map_tb_top import aout_pkg::*;;
  logic         CLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, HOST_LOST = 0, PAIR_LINK = 0;
  logic [1:0]   REG_SPACE = 0, NV_LD_SPACE, NV_WR_SPACE;
  logic [15:0]  REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, NV_LD_ADDR, NV_LD_DATA;
  logic [15:0]  NV_WR_ADDR, NV_WR_DATA;
  logic         REG_ACK, REG_ERR, NV_LD, NV_DONE, NV_WR, NV_FACTORY, REBOOT_REQ;
  logic         CAL_RESTORE, FORMAT_ENG, RUNNING;
  logic [7:0]   OVER_VALUE_TRIP = 0, WIRE_BREAK = 0, STATION_ID, OVER_VALUE_ALARM;
  logic [127:0] READBACK = 0, ANALOG_OUTPUT_LEVEL;
  logic [63:0]  ANALOG_OUTPUT_RANGE;
  logic [15:0]  codes [4] = '{16'h0030, 16'h0031, 16'h0032, 16'h0034};
  int           n_fail = 0, n_checks = 0, n;
  analog_output_regs #(.NCH(8), .RAMP_CYC(4)) u_analog_output_regs (.*);
  nv_store_model u_nv_store_model (.*);
  initial forever #12.5 CLK = ~CLK;
  task chk(input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // One access: request lasts one taking edge, answer awaited a few edges
  task acc(input logic w, input logic [1:0] s, input logic [15:0] ad, d, ee, ed);
    @(posedge CLK);
    {REG_WR, REG_RD, REG_SPACE, REG_ADDR, REG_WDATA} <= {w, !w, s, ad, d};
    @(posedge CLK);
    {REG_WR, REG_RD} <= 2'b00;
    n = 0;
    do @(posedge CLK); while (REG_ACK !== 1'b1 && ++n < 4);
    chk(REG_ERR, ee);
    chk(REG_RDATA, ed);
  endtask : acc
  task boot;
    SYS_RST <= 1'b1;
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    n = 0;
    do @(posedge CLK); while (RUNNING !== 1'b1 && ++n < 60);
    chk(RUNNING, 1);
  endtask : boot
  initial begin
    boot;
    acc(0, SP_HOLD, OFS_STATION, 0, 0, 1);
    acc(0, SP_HOLD, OFS_RANGE, 0, 0, 16'h0032);
    acc(0, SP_COIL, OFS_FACTORY, 0, 1, 0);
    foreach (codes[i]) acc(1, SP_HOLD, OFS_RANGE + 1, codes[i], 0, 0);
    acc(0, SP_HOLD, OFS_RANGE + 1, 0, 0, 16'h0034);
    chk(ANALOG_OUTPUT_RANGE[15:8], 16'h0034);
    acc(1, SP_HOLD, OFS_RANGE, 16'h0033, 1, 0);
    acc(1, SP_HOLD, OFS_STATION, 0, 1, 0);
    acc(1, SP_HOLD, OFS_STATION, 16'h00f8, 1, 0);
    acc(1, SP_HOLD, OFS_STATION, 16'h00f7, 0, 0);
    chk(STATION_ID, 16'h00f7);
    acc(1, SP_HOLD, OFS_OUT, 16'h1234, 0, 0);
    acc(0, SP_HOLD, OFS_OUT, 0, 0, 16'h1234);
    chk(ANALOG_OUTPUT_LEVEL[15:0], 16'h1234);
    acc(1, SP_COIL, OFS_FORMAT, 1, 0, 0);
    chk(FORMAT_ENG, 1);
    $display("access test done");
    boot;
    acc(0, SP_HOLD, OFS_STATION, 0, 0, 16'h00f7);
    acc(1, SP_COIL, OFS_CAL, 1, 0, 0);
    acc(1, SP_COIL, OFS_REBOOT, 1, 0, 0);
    // Writes are refused until the replayed image is done
    n = 0;
    do @(posedge CLK); while (RUNNING !== 1'b1 && ++n < 60);
    chk(RUNNING, 1);
    acc(1, SP_COIL, OFS_FACTORY, 1, 0, 0);
    boot;
    acc(0, SP_HOLD, OFS_STATION, 0, 0, 1);
    $display("storage test done");
    {PAIR_LINK, WIRE_BREAK, READBACK[47:32]} <= {1'b1, 8'h08, 16'h4e20};
    repeat (6) @(posedge CLK);
    acc(0, SP_INPUT, OFS_READBACK + 2, 0, 0, 16'h4e20);
    acc(0, SP_INPUT, OFS_CH_COUNT, 0, 0, 16'h0008);
    acc(0, SP_INPUT, OFS_FW_VER, 0, 0, 16'h0123);
    acc(0, SP_INPUT, OFS_PAIR, 0, 0, 1);
    acc(0, SP_DISC, OFS_WIRE_BREAK + 3, 0, 0, 1);
    acc(1, SP_COIL, OFS_OVP_EN, 1, 0, 0);
    OVER_VALUE_TRIP <= 8'h01;
    acc(0, SP_COIL, OFS_OVP_ALARM, 0, 0, 1);
    chk(OVER_VALUE_ALARM[0], 1);
    OVER_VALUE_TRIP <= 8'h00;
    acc(1, SP_COIL, OFS_OVP_ALARM, 1, 0, 0);
    acc(0, SP_COIL, OFS_OVP_ALARM, 0, 0, 0);
    $display("input test done");
    acc(1, SP_HOLD, OFS_SAFE + 1, 16'h0abc, 0, 0);
    HOST_LOST <= 1'b1;
    repeat (4) @(posedge CLK);
    chk(ANALOG_OUTPUT_LEVEL[31:16], 16'h0abc);
    acc(1, SP_HOLD, OFS_OUT + 1, 16'h0111, 0, 0);
    repeat (2) @(posedge CLK);
    chk(ANALOG_OUTPUT_LEVEL[31:16], 16'h0111);
    acc(1, SP_HOLD, OFS_SLEW, 1, 0, 0);
    acc(1, SP_HOLD, OFS_OUT, 16'h0010, 0, 0);
    chk(ANALOG_OUTPUT_LEVEL[15:0] < 16'h0004, 1);
    repeat (80) @(posedge CLK);
    chk(ANALOG_OUTPUT_LEVEL[15:0], 16'h0010);
    $display("output test done");
    conclude;
  end
  // Whole run needs well under this many cycles
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    conclude;
  end
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
endmodule : analog_output_register_map_tb_top
`default_nettype wire
